// *** include/ddac_pkg.sv ***
// Purpose: shared constants for the dual converter control registers
// Assumes: apb slave, 32-bit data, byte-addressed word registers
// Notes: printed offsets other than 0xA0 are not multiples of four, so they are indices
package ddac_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] DDAC_IDX_LVL1 = 8'h7D;
    localparam logic [7:0] DDAC_IDX_RSV1 = 8'h7E;
    localparam logic [7:0] DDAC_IDX_CTL1 = 8'h7F;
    localparam logic [7:0] DDAC_IDX_LVL2 = 8'hA0;
    localparam logic [7:0] DDAC_IDX_RSV2 = 8'hA1;
    localparam logic [7:0] DDAC_IDX_CTL2 = 8'hA2;
    localparam logic [1:0] DDAC_WORD_SHIFT = 2'd2;
    // control field positions
    localparam int DDAC_EN_BIT = 7;
    localparam int DDAC_OE_HI = 5;
    localparam int DDAC_OE_LO = 4;
    localparam int DDAC_PSS_HI = 3;
    localparam int DDAC_PSS_LO = 2;
    localparam int DDAC_NSS_BIT = 0;
    // writable masks
    localparam logic [7:0] DDAC_CTL1_MASK = 8'hBD;
    localparam logic [7:0] DDAC_CTL2_MASK = 8'h8D;
    // reset values
    localparam logic [7:0] DDAC_CTL_RST = 8'h00;
    localparam logic [7:0] DDAC_LVL_RST = 8'h00;
    // output pin select codes
    localparam logic [1:0] DDAC_OE_PIN_ZERO = 2'b01;
    localparam logic [1:0] DDAC_OE_PIN_TWO = 2'b10;
    // positive reference codes
    localparam logic [1:0] DDAC_PSS_SUPPLY = 2'b00;
    localparam logic [1:0] DDAC_PSS_EXT = 2'b01;
    localparam logic [1:0] DDAC_PSS_FIXED = 2'b10;
endpackage

// *** design/ddac_channel.sv ***
// Purpose: one converter instance: control and level registers, analog-side outputs
// Assumes: write strobe already decoded by the bus slave
// Notes: pin selector exists only when has_pins is set
`timescale 1ns/1ps
module ddac_channel
    import ddac_pkg::*;
#(
    parameter bit has_pins = 1'b1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wr_ctl,
    input wire logic wr_lvl,
    input wire logic [7:0] wdata,
    output logic [7:0] ctl,
    output logic [7:0] lvl,
    output logic enable,
    output logic pin_zero_en,
    output logic pin_two_en,
    output logic [1:0] pos_ref_sel,
    output logic neg_ref_sel,
    output logic [7:0] level_code
);
    localparam logic [7:0] ctl_mask = has_pins ? DDAC_CTL1_MASK : DDAC_CTL2_MASK;
    logic [1:0] oe;

    // only reset clears; a sleep wake has no port here, so state survives
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctl <= DDAC_CTL_RST;
        end else if (wr_ctl) begin
            ctl <= wdata & ctl_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lvl <= DDAC_LVL_RST;
        end else if (wr_lvl) begin
            lvl <= wdata;
        end
    end

    assign oe = ctl[DDAC_OE_HI:DDAC_OE_LO];

    // analog-side outputs registered, so new values show one cycle after the write edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable <= 1'b0;
            pin_zero_en <= 1'b0;
            pin_two_en <= 1'b0;
            pos_ref_sel <= DDAC_PSS_SUPPLY;
            neg_ref_sel <= 1'b0;
            level_code <= DDAC_LVL_RST;
        end else begin
            enable <= ctl[DDAC_EN_BIT];
            // pins need the instance enabled; codes 00 and 11 drive no pin
            pin_zero_en <= has_pins && ctl[DDAC_EN_BIT] && (oe == DDAC_OE_PIN_ZERO);
            pin_two_en <= has_pins && ctl[DDAC_EN_BIT] && (oe == DDAC_OE_PIN_TWO);
            pos_ref_sel <= ctl[DDAC_PSS_HI:DDAC_PSS_LO];
            neg_ref_sel <= ctl[DDAC_NSS_BIT];
            level_code <= lvl;
        end
    end

    property p_one_hot;
        @(posedge clk_sys) disable iff (sys_rst)
        !(pin_zero_en && pin_two_en);
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("both pins driven");

    property p_level_follow;
        @(posedge clk_sys) disable iff (sys_rst)
        wr_lvl |=> ##1 (level_code == $past(wdata, 2));
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level not presented");

    property p_enable_follow;
        @(posedge clk_sys) disable iff (sys_rst)
        wr_ctl |=> ##1 (enable == $past(wdata[DDAC_EN_BIT], 2));
    endproperty
    a_enable_follow: assert property (p_enable_follow) else $error("enable mismatch");

    property p_unimpl_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        (ctl & ~ctl_mask) == 8'h00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_pin_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        pin_zero_en |-> ($past(oe) == DDAC_OE_PIN_ZERO) && $past(ctl[DDAC_EN_BIT]);
    endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("pin zero without code");

    property p_no_pins2;
        @(posedge clk_sys) disable iff (sys_rst)
        !has_pins |-> !pin_zero_en && !pin_two_en;
    endproperty
    a_no_pins2: assert property (p_no_pins2) else $error("second instance drove a pin");

    property p_pss_follow;
        @(posedge clk_sys) disable iff (sys_rst)
        wr_ctl |=> ##1 (pos_ref_sel == $past(wdata[DDAC_PSS_HI:DDAC_PSS_LO], 2));
    endproperty
    a_pss_follow: assert property (p_pss_follow) else $error("reference select mismatch");

    property p_nss_follow;
        @(posedge clk_sys) disable iff (sys_rst)
        wr_ctl |=> ##1 (neg_ref_sel == $past(wdata[DDAC_NSS_BIT], 2));
    endproperty
    a_nss_follow: assert property (p_nss_follow) else $error("negative select mismatch");
endmodule // ddac_channel

// *** design/ddac_top.sv ***
// Purpose: apb register slave for two converter instances
// Assumes: single clock, synchronous active-high reset
// Notes: zero-wait answers; unmapped addresses read zero with pslverr
// Summary of operation
// - an instance runs only while its control bit 7 is set
// - first instance bits 5:4: 10 pin two, 01 pin zero, else none
// - bits 3:2 pick positive reference: supply, external pin, fixed buffer
// - bit 0 picks negative reference: 1 external pin, 0 ground
// - each instance holds a read-write 8-bit level code, reset zero
// - second instance has no pin selector; feeds only internal blocks
// - first instance control at 0x7F, level at 0x7D, 0x7E reserved
// - second instance level at 0xA0, control at 0xA2, 0xA1 reserved
// - reset disables instances, removes pin drive, clears level codes
// - wake from sleep leaves control and level registers unchanged
// - at most one output pin enabled at any time
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module ddac_top
    import ddac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic conv1_enable,
    output logic port_a_pin_zero_en,
    output logic port_a_pin_two_en,
    output logic [1:0] conv1_positive_reference_select,
    output logic conv1_negative_reference_select,
    output logic [7:0] conv1_level_code,
    output logic conv2_enable,
    output logic [1:0] conv2_positive_reference_select,
    output logic conv2_negative_reference_select,
    output logic [7:0] conv2_level_code
);
    logic [7:0] ctl1;
    logic [7:0] lvl1;
    logic [7:0] ctl2;
    logic [7:0] lvl2;
    logic [9:0] word_idx;
    logic setup;
    logic wr_byte;
    logic hit;
    logic [7:0] rd_val;

    // byte address to register index
    function automatic logic is_idx(input logic [9:0] w, input logic [7:0] idx);
        return w == {2'b00, idx};
    endfunction

    assign word_idx = paddr[11:DDAC_WORD_SHIFT];
    // answer in the access cycle's first edge; commit there too
    assign setup = psel && !penable;
    assign wr_byte = psel && penable && pwrite && pstrb[0];

    always_comb begin
        hit = 1'b1;
        rd_val = 8'h00;
        if (is_idx(word_idx, DDAC_IDX_LVL1)) begin
            rd_val = lvl1;
        end else if (is_idx(word_idx, DDAC_IDX_CTL1)) begin
            rd_val = ctl1;
        end else if (is_idx(word_idx, DDAC_IDX_LVL2)) begin
            rd_val = lvl2;
        end else if (is_idx(word_idx, DDAC_IDX_CTL2)) begin
            rd_val = ctl2;
        end else if (is_idx(word_idx, DDAC_IDX_RSV1) || is_idx(word_idx, DDAC_IDX_RSV2)) begin
            rd_val = 8'h00; // reserved: reads zero, no error
        end else begin
            hit = 1'b0;
        end
    end

    // pready rises one edge after setup, giving one-wait-free access phase
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
            prdata <= (setup && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    // pready is high only in the access cycle, so the commit is that one edge
    ddac_channel #(.has_pins(1'b1)) u_conv1 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_ctl(wr_byte && pready && is_idx(word_idx, DDAC_IDX_CTL1)),
        .wr_lvl(wr_byte && pready && is_idx(word_idx, DDAC_IDX_LVL1)),
        .wdata(pwdata[7:0]),
        .ctl(ctl1),
        .lvl(lvl1),
        .enable(conv1_enable),
        .pin_zero_en(port_a_pin_zero_en),
        .pin_two_en(port_a_pin_two_en),
        .pos_ref_sel(conv1_positive_reference_select),
        .neg_ref_sel(conv1_negative_reference_select),
        .level_code(conv1_level_code)
    );

    // no pin outputs exist for the second instance
    ddac_channel #(.has_pins(1'b0)) u_conv2 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_ctl(wr_byte && pready && is_idx(word_idx, DDAC_IDX_CTL2)),
        .wr_lvl(wr_byte && pready && is_idx(word_idx, DDAC_IDX_LVL2)),
        .wdata(pwdata[7:0]),
        .ctl(ctl2),
        .lvl(lvl2),
        .enable(conv2_enable),
        .pin_zero_en(),
        .pin_two_en(),
        .pos_ref_sel(conv2_positive_reference_select),
        .neg_ref_sel(conv2_negative_reference_select),
        .level_code(conv2_level_code)
    );

    // code 11 is stored as written; the analog side treats it as undefined

    property p_ready_one;
        @(posedge clk_sys) disable iff (sys_rst)
        (psel && !penable) |=> pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("no answer after setup");

    property p_reset_clear;
        @(posedge clk_sys)
        sys_rst |=> ##1 (conv1_level_code == 8'h00 && !port_a_pin_two_en && !conv2_enable);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

    property p_ctl1_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (setup && !pwrite && is_idx(word_idx, DDAC_IDX_CTL1)) |=> prdata[7:0] == ctl1;
    endproperty
    a_ctl1_read: assert property (p_ctl1_read) else $error("control read mismatch");

    property p_rsv_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (setup && !pwrite && is_idx(word_idx, DDAC_IDX_RSV2)) |=> prdata == 32'h0 && !pslverr;
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("reserved read nonzero");

    property p_idle_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        !psel |=> $stable(ctl1) && $stable(lvl2);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("register changed without write");
endmodule // ddac_top

// *** dv/dual_dac_control_regs_tb_top.sv ***
// Purpose: self-checking bench for the dual converter control registers
// Assumes: zero-wait apb slave, outputs follow one cycle after a write lands
// Notes: random mix keeps the reserved reference code out of writes
`timescale 1ns/1ps
module dual_dac_control_regs_tb_top
    import ddac_pkg::*;
;
    logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [3:0] pstrb, st;
    logic c1_en, pz, pt, c1_neg, c2_en, c2_neg;
    logic [1:0] c1_pos, c2_pos;
    logic [7:0] c1_lvl, c2_lvl, m_ctl1, m_lvl1, m_ctl2, m_lvl2, idx;
    int mismatches, n_tests;
    integer seed;
    logic [7:0] idx_tab [8] = '{DDAC_IDX_LVL1, DDAC_IDX_RSV1, DDAC_IDX_CTL1, DDAC_IDX_LVL2,
        DDAC_IDX_RSV2, DDAC_IDX_CTL2, 8'h7C, 8'h3F};

    ddac_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv1_enable(c1_en), .port_a_pin_zero_en(pz),
        .port_a_pin_two_en(pt), .conv1_positive_reference_select(c1_pos),
        .conv1_negative_reference_select(c1_neg), .conv1_level_code(c1_lvl),
        .conv2_enable(c2_en), .conv2_positive_reference_select(c2_pos),
        .conv2_negative_reference_select(c2_neg), .conv2_level_code(c2_lvl));

    task stop_test;
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask

    function logic [31:0] exp_rd(input logic [7:0] i);
        case (i)
            DDAC_IDX_LVL1: exp_rd = {24'h00_0000, m_lvl1};
            DDAC_IDX_CTL1: exp_rd = {24'h00_0000, m_ctl1};
            DDAC_IDX_LVL2: exp_rd = {24'h00_0000, m_lvl2};
            DDAC_IDX_CTL2: exp_rd = {24'h00_0000, m_ctl2};
            default: exp_rd = 32'h0000_0000;
        endcase
    endfunction

    task check_outs;
        chk("c1_en", c1_en, m_ctl1[7]);
        chk("pin_zero", pz, m_ctl1[7] && m_ctl1[5:4] == 2'b01);
        chk("pin_two", pt, m_ctl1[7] && m_ctl1[5:4] == 2'b10);
        chk("one_hot", pz & pt, 1'b0);
        chk("c1_pos", c1_pos, m_ctl1[3:2]);
        chk("c1_neg", c1_neg, m_ctl1[0]);
        chk("c1_lvl", c1_lvl, m_lvl1);
        chk("c2_en", c2_en, m_ctl2[7]);
        chk("c2_pos", c2_pos, m_ctl2[3:2]);
        chk("c2_neg", c2_neg, m_ctl2[0]);
        chk("c2_lvl", c2_lvl, m_lvl2);
    endtask

    // request held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] i, input logic [31:0] wd, input logic [3:0] s);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= wd;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task acc(input logic w, input logic [7:0] i, input logic [31:0] wd, input logic [3:0] s);
        logic mapped;
        mapped = i inside {DDAC_IDX_LVL1, DDAC_IDX_RSV1, DDAC_IDX_CTL1, DDAC_IDX_LVL2,
            DDAC_IDX_RSV2, DDAC_IDX_CTL2};
        apb(w, i, wd, s);
        chk("pslverr", err, !mapped);
        if (!w) chk("prdata", rd, exp_rd(i));
        #1;
        check_outs();
        if (w && s[0]) begin
            case (i)
                DDAC_IDX_LVL1: m_lvl1 = wd[7:0];
                DDAC_IDX_CTL1: m_ctl1 = wd[7:0] & DDAC_CTL1_MASK;
                DDAC_IDX_LVL2: m_lvl2 = wd[7:0];
                DDAC_IDX_CTL2: m_ctl2 = wd[7:0] & DDAC_CTL2_MASK;
                default: ;
            endcase
        end
        @(posedge clk_sys);
        #1;
        check_outs();
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end

    initial begin
        seed = 32'hebc8_cf3a;
        {sys_rst, psel, penable, pwrite} = 4'h8;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        {m_ctl1, m_lvl1, m_ctl2, m_lvl2} = 32'h0000_0000;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        check_outs();
        for (int i = 0; i < 8; i++) acc(1'b0, idx_tab[i], 32'h0000_0000, 4'h0);
        // every pin, reference and enable code, unimplemented bits set
        for (int i = 0; i < 24; i++) begin
            d = {24'h00_0000, i[2], 1'b1, i[1:0], 2'(i / 8), 1'b1, i[0] ^ i[2]};
            acc(1'b1, DDAC_IDX_CTL1, d, 4'h1);
            acc(1'b1, DDAC_IDX_CTL2, d, 4'h1);
            acc(1'b0, DDAC_IDX_CTL2, 32'h0000_0000, 4'h0);
        end
        // lane zero clear: the write must not land
        acc(1'b1, DDAC_IDX_LVL1, 32'h0000_00A5, 4'hE);
        acc(1'b0, DDAC_IDX_LVL1, 32'h0000_0000, 4'h0);
        for (int n = 0; n < 200; n++) begin
            idx = idx_tab[$unsigned($random(seed)) % 8];
            d = $random(seed);
            if (d[3:2] == 2'b11) d[3] = 1'b0; // software keeps off the reserved code
            st = $random(seed);
            st[0] = st[0] | st[1];
            acc(d[31], idx, d, st);
        end
        // second reset in mid-run wipes every register
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        {m_ctl1, m_lvl1, m_ctl2, m_lvl2} = 32'h0000_0000;
        #1;
        check_outs();
        for (int i = 0; i < 6; i++) acc(1'b0, idx_tab[i], 32'h0000_0000, 4'h0);
        stop_test();
    end
endmodule // dual_dac_control_regs_tb_top
